// [bench/sbl_bank_state_legality_test.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module sbl_bank_state_legality_test
    import sbl_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    sbl_cmd_t r_cmd = SBL_CMD_NOP;
    logic [1:0] r_bank = 2'h0;
    logic r_ap = 1'b0;
    logic r_gate = 1'b1;
    int n_mismatch = 0;
    int checks_done = 0;
    wire logic clock_gate, chip_select_n, row_strobe_n, column_strobe_n, write_strobe_n;
    wire logic [1:0] bank_select;
    wire logic [SBL_ADDR_W-1:0] addr;
    wire logic [2*SBL_BANKS*2-1:0] bank_state;
    wire logic [2:0] dev_state;
    wire logic all_idle, illegal;
    // 100 MHz clock
    always #5 clk = ~clk;
    sbl_ctrl_model u_ctrl (.clk(clk), .rst_n(rst_n), .req_cmd(r_cmd), .req_bank(r_bank),
        .req_ap(r_ap), .req_gate(r_gate), .clock_gate(clock_gate),
        .chip_select_n(chip_select_n), .row_strobe_n(row_strobe_n),
        .column_strobe_n(column_strobe_n), .write_strobe_n(write_strobe_n),
        .bank_select(bank_select), .addr(addr));
    sbl_bank_state_legality u_dut (.clk(clk), .rst_n(rst_n), .clock_gate(clock_gate),
        .chip_select_n(chip_select_n), .row_strobe_n(row_strobe_n),
        .column_strobe_n(column_strobe_n), .write_strobe_n(write_strobe_n),
        .bank_select(bank_select), .addr(addr), .bank_state(bank_state),
        .dev_state(dev_state), .all_idle(all_idle), .illegal(illegal));
    function automatic logic [2:0] bk(input int k);
        return bank_state[4*k +: 3];
    endfunction : bk
    // Drive one request after an edge, then let that edge's updates land
    task automatic cyc(input sbl_cmd_t c, input logic [1:0] b, input logic ap, input logic g);
        @(posedge clk);
        r_cmd <= c;
        r_bank <= b;
        r_ap <= ap;
        r_gate <= g;
        #1;
    endtask : cyc
    task automatic nop();
        cyc(SBL_CMD_NOP, 2'h0, 1'b0, 1'b1);
    endtask : nop
    task automatic go(input sbl_cmd_t c, input logic [1:0] b, input logic ap);
        cyc(c, b, ap, 1'b1);
        nop();
    endtask : go
    // Count cycles a bank (0..3) or the device (4) stays in one state
    task automatic dwell(input int k, input logic [2:0] s, input logic [SBL_CNT_W-1:0] e);
        int n;
        n = 0;
        while ((((k == 4) ? dev_state : bk(k)) === s) && n < 200) begin
            nop();
            n++;
        end
        `CHK(SBL_CNT_W'(n), e)
    endtask : dwell
    task automatic t_access();
        go(SBL_CMD_ACTIVATE, 2'h0, 1'b0);
        `CHK(all_idle, 1'b0)
        dwell(0, SBL_BK_ACTIVATING, SBL_ACTIVATE_CYC);
        go(SBL_CMD_READ, 2'h0, 1'b0);
        dwell(0, SBL_BK_READ, SBL_BURST_CYC);
        go(SBL_CMD_INHIBIT, 2'h0, 1'b0);
        `CHK(bk(0), SBL_BK_ACTIVE)
        go(SBL_CMD_WRITE, 2'h0, 1'b1);
        dwell(0, SBL_BK_WRITE_AP, SBL_BURST_CYC);
        dwell(0, SBL_BK_PRECHARGING, SBL_PRECHARGE_CYC);
        `CHK(all_idle, 1'b1)
        $display("t_access done");
    endtask : t_access
    task automatic t_cross();
        cyc(SBL_CMD_ACTIVATE, 2'h0, 1'b0, 1'b1);
        cyc(SBL_CMD_ACTIVATE, 2'h2, 1'b0, 1'b1);
        repeat (4) nop();
        cyc(SBL_CMD_WRITE, 2'h0, 1'b0, 1'b1);
        cyc(SBL_CMD_READ, 2'h2, 1'b0, 1'b1);
        cyc(SBL_CMD_TERMINATE, 2'h0, 1'b0, 1'b1);
        `CHK(bk(2), SBL_BK_READ)
        nop();
        `CHK(bk(2), SBL_BK_ACTIVE)
        `CHK(bk(0), SBL_BK_ACTIVE)
        go(SBL_CMD_PRECHARGE, 2'h1, 1'b1); // all banks prechargeable here
        dwell(4, SBL_DV_PRECHARGE_ALL, SBL_PRECHARGE_CYC);
        `CHK(all_idle, 1'b1)
        $display("t_cross done");
    endtask : t_cross
    task automatic t_refused();
        go(SBL_CMD_PRECHARGE, 2'h0, 1'b0);
        `CHK(all_idle, 1'b1)
        cyc(SBL_CMD_ACTIVATE, 2'h3, 1'b0, 1'b1);
        cyc(SBL_CMD_READ, 2'h3, 1'b0, 1'b1); // deliberately too early
        nop();
        `CHK(illegal, 1'b1)
        `CHK(bk(3), SBL_BK_ACTIVATING)
        go(SBL_CMD_REFRESH, 2'h0, 1'b0); // with a bank open
        `CHK(illegal, 1'b1)
        `CHK(dev_state, SBL_DV_NORMAL)
        repeat (8) nop();
        `CHK(illegal, 1'b0)
        go(SBL_CMD_PRECHARGE, 2'h3, 1'b0);
        repeat (3) nop();
        go(SBL_CMD_REFRESH, 2'h0, 1'b0);
        dwell(4, SBL_DV_REFRESHING, SBL_REFRESH_CYC);
        go(SBL_CMD_MODE_LOAD, 2'h0, 1'b0);
        dwell(4, SBL_DV_MODE_LOADING, SBL_MODE_LOAD_CYC);
        `CHK(all_idle, 1'b1)
        $display("t_refused done");
    endtask : t_refused
    task automatic t_gate();
        repeat (4) cyc(SBL_CMD_NOP, 2'h0, 1'b0, 1'b0);
        `CHK(dev_state, SBL_DV_POWER_DOWN)
        cyc(SBL_CMD_NOP, 2'h0, 1'b0, 1'b1);
        go(SBL_CMD_ACTIVATE, 2'h0, 1'b0);
        `CHK(bk(0), SBL_BK_ACTIVATING)
        repeat (3) nop();
        go(SBL_CMD_PRECHARGE, 2'h0, 1'b0);
        repeat (3) nop();
        cyc(SBL_CMD_REFRESH, 2'h0, 1'b0, 1'b0);
        repeat (3) cyc(SBL_CMD_NOP, 2'h0, 1'b0, 1'b0);
        `CHK(dev_state, SBL_DV_SELF_REFRESH)
        go(SBL_CMD_NOP, 2'h0, 1'b0);
        dwell(4, SBL_DV_SR_EXIT, SBL_SR_EXIT_CYC);
        go(SBL_CMD_ACTIVATE, 2'h0, 1'b0);
        repeat (3) nop();
        cyc(SBL_CMD_WRITE, 2'h0, 1'b0, 1'b1);
        repeat (6) cyc(SBL_CMD_NOP, 2'h0, 1'b0, 1'b0);
        `CHK(dev_state, SBL_DV_SUSPEND)
        `CHK(bk(0), SBL_BK_WRITE)
        go(SBL_CMD_NOP, 2'h0, 1'b0);
        `CHK(dev_state, SBL_DV_NORMAL)
        repeat (8) nop();
        `CHK(bk(0), SBL_BK_ACTIVE)
        go(SBL_CMD_PRECHARGE, 2'h0, 1'b0);
        repeat (3) nop();
        $display("t_gate done");
    endtask : t_gate
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize
    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_access();
        t_cross();
        t_refused();
        t_gate();
        summarize();
    end
    // Watchdog: the tests need well under 500 cycles
    initial begin
        #20000;
        n_mismatch++;
        summarize();
    end
endmodule : sbl_bank_state_legality_test
bind sbl_bank_state_legality sbl_checker u_chk (.clk(clk), .rst_n(rst_n),
    .clock_gate(clock_gate), .chip_select_n(chip_select_n), .row_strobe_n(row_strobe_n),
    .column_strobe_n(column_strobe_n), .write_strobe_n(write_strobe_n),
    .bank_select(bank_select), .addr(addr), .bank_state(bank_state),
    .dev_state(dev_state), .all_idle(all_idle), .illegal(illegal));
`default_nettype wire

// [bench/sbl_checker.sv]
`timescale 1ns/1ps
`default_nettype none
// Pin-level checks beside the legality block
module sbl_checker
    import sbl_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Command pins
    input wire logic clock_gate,
    input wire logic chip_select_n,
    input wire logic row_strobe_n,
    input wire logic column_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [1:0] bank_select,
    input wire logic [SBL_ADDR_W-1:0] addr,
    // Observed state
    input wire logic [2*SBL_BANKS*2-1:0] bank_state,
    input wire logic [2:0] dev_state,
    input wire logic all_idle,
    input wire logic illegal
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic gate_q_r;
    // Previous gate sample, taken as high out of reset like the block
    always_ff @(posedge clk) begin
        gate_q_r <= rst_n ? clock_gate : 1'b1;
    end
    // Decode; strobes count only under a low select
    wire logic [2:0] stb = {row_strobe_n, column_strobe_n, write_strobe_n};
    wire logic quiet = chip_select_n | (stb == 3'h7);
    wire logic b0 = !chip_select_n && (bank_select == 2'h0);
    wire logic up = (dev_state == SBL_DV_NORMAL) && gate_q_r;
    wire logic run = up && clock_gate;
    wire logic [2:0] st0 = bank_state[2:0];
    sequence s_act0;
        run && b0 && (stb == 3'h3) && (st0 == SBL_BK_IDLE);
    endsequence
    sequence s_pre0;
        run && b0 && (stb == 3'h2) && !addr[10] && (st0 == SBL_BK_ACTIVE);
    endsequence
    property p_activate;
        s_act0 |=> (st0 == SBL_BK_ACTIVATING) [*2] ##1 (st0 == SBL_BK_ACTIVE);
    endproperty
    property p_precharge;
        s_pre0 |=> (st0 == SBL_BK_PRECHARGING) [*2] ##1 (st0 == SBL_BK_IDLE);
    endproperty
    property p_read;
        run && b0 && (stb == 3'h5) && !addr[10] && (st0 == SBL_BK_ACTIVE)
            |=> st0 == SBL_BK_READ;
    endproperty
    property p_write_ap;
        run && b0 && (stb == 3'h4) && addr[10] && (st0 == SBL_BK_ACTIVE)
            |=> st0 == SBL_BK_WRITE_AP;
    endproperty
    property p_idle_pre;
        run && b0 && (stb == 3'h2) && !addr[10] && all_idle |=> all_idle && !illegal;
    endproperty
    property p_quiet;
        run && quiet && all_idle |=> all_idle && !illegal;
    endproperty
    property p_hold_low;
        !clock_gate && !gate_q_r && (dev_state inside {SBL_DV_POWER_DOWN,
            SBL_DV_SELF_REFRESH, SBL_DV_SUSPEND}) |=> $stable(dev_state) && $stable(bank_state);
    endproperty
    property p_pd_entry;
        up && !clock_gate && quiet && all_idle |=> dev_state == SBL_DV_POWER_DOWN;
    endproperty
    property p_sr_entry;
        up && !clock_gate && !chip_select_n && (stb == 3'h1) && all_idle
            |=> dev_state == SBL_DV_SELF_REFRESH;
    endproperty
    property p_pd_exit;
        (dev_state == SBL_DV_POWER_DOWN) && clock_gate && quiet |=> dev_state == SBL_DV_NORMAL;
    endproperty
    property p_susp_exit;
        (dev_state == SBL_DV_SUSPEND) && clock_gate |=> dev_state == SBL_DV_NORMAL;
    endproperty
    property p_refused;
        illegal |-> $stable(bank_state) && $stable(dev_state);
    endproperty
    a_activate: assert property (p_activate) else $error("activate timing wrong");
    a_precharge: assert property (p_precharge) else $error("precharge timing wrong");
    a_read: assert property (p_read) else $error("read not started");
    a_write_ap: assert property (p_write_ap) else $error("auto precharge lost");
    a_idle_pre: assert property (p_idle_pre) else $error("idle precharge acted");
    a_quiet: assert property (p_quiet) else $error("nop changed state");
    a_hold_low: assert property (p_hold_low) else $error("low gate state moved");
    a_pd_entry: assert property (p_pd_entry) else $error("no power-down");
    a_sr_entry: assert property (p_sr_entry) else $error("no self refresh");
    a_pd_exit: assert property (p_pd_exit) else $error("power-down exit late");
    a_susp_exit: assert property (p_susp_exit) else $error("suspend exit late");
    a_refused: assert property (p_refused) else $error("refused command acted");
endmodule : sbl_checker
`default_nettype wire

// [bench/sbl_ctrl_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Controller stand-in: puts bench requests on the command pins
module sbl_ctrl_model
    import sbl_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Requests
    input wire sbl_cmd_t req_cmd,
    input wire logic [1:0] req_bank,
    input wire logic req_ap,
    input wire logic req_gate,
    // Command pins
    output logic clock_gate,
    output logic chip_select_n,
    output logic row_strobe_n,
    output logic column_strobe_n,
    output logic write_strobe_n,
    output logic [1:0] bank_select,
    output logic [SBL_ADDR_W-1:0] addr
);
    logic [SBL_CNT_W-1:0] hold_r;
    logic sr_r;
    logic gate_q_r;
    logic [2:0] tog_r;
    logic [2:0] stb;
    // While a device-wide wait runs only nops go out
    wire logic busy = hold_r != SBL_CNT_ZERO;
    wire sbl_cmd_t cmd = busy ? SBL_CMD_NOP : req_cmd;
    wire logic rise = req_gate && !gate_q_r;
    // Strobe encoding
    always_comb begin
        case (cmd)
            SBL_CMD_ACTIVATE: stb = 3'h3;
            SBL_CMD_READ: stb = 3'h5;
            SBL_CMD_WRITE: stb = 3'h4;
            SBL_CMD_TERMINATE: stb = 3'h6;
            SBL_CMD_PRECHARGE: stb = 3'h2;
            SBL_CMD_REFRESH: stb = 3'h1;
            SBL_CMD_MODE_LOAD: stb = 3'h0;
            default: stb = 3'h7;
        endcase
    end
    // Strobes wander under inhibit, so a loose decode shows up
    assign chip_select_n = cmd == SBL_CMD_INHIBIT;
    assign {row_strobe_n, column_strobe_n, write_strobe_n} = chip_select_n ? tog_r : stb;
    assign clock_gate = req_gate;
    assign bank_select = req_bank;
    assign addr = {req_ap, 10'h2AA};
    // Wait tracking; conservative, one extra nop costs nothing
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hold_r <= SBL_CNT_ZERO;
            sr_r <= 1'b0;
            gate_q_r <= 1'b1;
            tog_r <= 3'h0;
        end else begin
            gate_q_r <= req_gate;
            tog_r <= tog_r + 3'h3;
            sr_r <= (sr_r | (gate_q_r && cmd == SBL_CMD_REFRESH)) && !req_gate;
            hold_r <= (rise && sr_r) ? SBL_SR_EXIT_CYC :
                busy ? hold_r - 8'h01 :
                !req_gate ? SBL_CNT_ZERO :
                (cmd == SBL_CMD_REFRESH) ? SBL_REFRESH_CYC :
                (cmd == SBL_CMD_MODE_LOAD) ? SBL_MODE_LOAD_CYC :
                (cmd == SBL_CMD_PRECHARGE && req_ap) ? SBL_PRECHARGE_CYC : SBL_CNT_ZERO;
        end
    end
endmodule : sbl_ctrl_model
`default_nettype wire

// [inc/sbl_pkg.sv]
package sbl_pkg;
    // Command codes after decode of select and the three strobes
    typedef enum logic [3:0] {
        SBL_CMD_INHIBIT,
        SBL_CMD_NOP,
        SBL_CMD_ACTIVATE,
        SBL_CMD_READ,
        SBL_CMD_WRITE,
        SBL_CMD_TERMINATE,
        SBL_CMD_PRECHARGE,
        SBL_CMD_REFRESH,
        SBL_CMD_MODE_LOAD
    } sbl_cmd_t;

    // Per-bank state
    typedef enum logic [2:0] {
        SBL_BK_IDLE,
        SBL_BK_ACTIVATING,
        SBL_BK_ACTIVE,
        SBL_BK_READ,
        SBL_BK_WRITE,
        SBL_BK_READ_AP,
        SBL_BK_WRITE_AP,
        SBL_BK_PRECHARGING
    } sbl_bank_t;

    // Device-wide state
    typedef enum logic [2:0] {
        SBL_DV_NORMAL,
        SBL_DV_POWER_DOWN,
        SBL_DV_SELF_REFRESH,
        SBL_DV_SR_EXIT,
        SBL_DV_SUSPEND,
        SBL_DV_REFRESHING,
        SBL_DV_MODE_LOADING,
        SBL_DV_PRECHARGE_ALL
    } sbl_dev_t;

    localparam int SBL_BANKS = 4;
    localparam int SBL_CNT_W = 8;
    localparam int SBL_AP_BIT = 10;
    localparam int SBL_ADDR_W = 11;

    // Clock period and waits in ps; cycle counts round up (least times)
    localparam int SBL_CLK_PS = 10000;
    localparam int SBL_PRECHARGE_TIME_PS = 20000;
    localparam int SBL_ACTIVATE_TO_ACCESS_TIME_PS = 20000;
    localparam int SBL_REFRESH_CYCLE_TIME_PS = 70000;
    localparam int SBL_MODE_LOAD_DELAY_PS = 20000;
    localparam int SBL_SELF_REFRESH_EXIT_TIME_PS = 80000;
    localparam int SBL_BURST_CYCLES_DEF = 4;

    localparam logic [SBL_CNT_W-1:0] SBL_PRECHARGE_CYC =
        SBL_CNT_W'((SBL_PRECHARGE_TIME_PS + SBL_CLK_PS - 1) / SBL_CLK_PS);
    localparam logic [SBL_CNT_W-1:0] SBL_ACTIVATE_CYC =
        SBL_CNT_W'((SBL_ACTIVATE_TO_ACCESS_TIME_PS + SBL_CLK_PS - 1) / SBL_CLK_PS);
    localparam logic [SBL_CNT_W-1:0] SBL_REFRESH_CYC =
        SBL_CNT_W'((SBL_REFRESH_CYCLE_TIME_PS + SBL_CLK_PS - 1) / SBL_CLK_PS);
    localparam logic [SBL_CNT_W-1:0] SBL_MODE_LOAD_CYC =
        SBL_CNT_W'((SBL_MODE_LOAD_DELAY_PS + SBL_CLK_PS - 1) / SBL_CLK_PS);
    localparam logic [SBL_CNT_W-1:0] SBL_SR_EXIT_CYC =
        SBL_CNT_W'((SBL_SELF_REFRESH_EXIT_TIME_PS + SBL_CLK_PS - 1) / SBL_CLK_PS);
    localparam logic [SBL_CNT_W-1:0] SBL_BURST_CYC = SBL_CNT_W'(SBL_BURST_CYCLES_DEF);
    localparam logic [SBL_CNT_W-1:0] SBL_CNT_ZERO = 8'h00;
endpackage : sbl_pkg

// [rtl/sbl_bank_state_legality.sv]
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Previous and current clock_gate select action
// - Gate fall enters power-down, self refresh, suspend
// - Power-down exit ready on next edge
// - Suspend exit resumes, next command next edge
// - Bank tables only with gate high twice
// - Decode command from select and three strobes
// - Inhibit and nop change no bank state
// - Idle bank takes activate, refresh, mode, precharge
// - Active bank takes read, write, precharge
// - Read burst takes read, write, terminate, precharge
// - Write burst takes read, write, terminate, precharge
// - Terminate stops most recent burst, any bank
// - Precharging becomes idle after precharge time
// - Activating becomes active after activate delay
// - Other-bank commands allowed per its state
// - Address bit ten selects auto precharge or all
// - Refresh code with gate low enters self refresh
module sbl_bank_state_legality
    import sbl_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Command pins from the controller
    input wire logic clock_gate,
    input wire logic chip_select_n,
    input wire logic row_strobe_n,
    input wire logic column_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [1:0] bank_select,
    input wire logic [SBL_ADDR_W-1:0] addr,
    // Observed state
    output logic [2*SBL_BANKS*2-1:0] bank_state,
    output logic [2:0] dev_state,
    output logic all_idle,
    output logic illegal
);
    // Per-bank state and its wait counter
    sbl_bank_t bank_r [SBL_BANKS], bank_nxt [SBL_BANKS];
    logic [SBL_CNT_W-1:0] bcnt_r [SBL_BANKS], bcnt_nxt [SBL_BANKS];
    sbl_dev_t dev_r, dev_nxt;
    logic [SBL_CNT_W-1:0] dcnt_r, dcnt_nxt;
    logic [1:0] last_burst_r, last_burst_nxt;
    logic last_valid_r, last_valid_nxt;
    logic gate_prev_r, illegal_nxt;
    logic [2*SBL_BANKS*2-1:0] bank_state_nxt;
    logic any_burst, every_idle, every_pre_ok;
    // Command decode
    function automatic sbl_cmd_t sbl_decode(input logic cs, input logic ras,
                                            input logic cas, input logic we);
        if (cs)
            return SBL_CMD_INHIBIT;
        case ({ras, cas, we})
            3'h7: return SBL_CMD_NOP;
            3'h3: return SBL_CMD_ACTIVATE;
            3'h5: return SBL_CMD_READ;
            3'h4: return SBL_CMD_WRITE;
            3'h6: return SBL_CMD_TERMINATE;
            3'h2: return SBL_CMD_PRECHARGE;
            3'h1: return SBL_CMD_REFRESH;
            default: return SBL_CMD_MODE_LOAD;
        endcase
    endfunction : sbl_decode
    // A bank that may take an explicit precharge
    function automatic logic sbl_pre_ok(input sbl_bank_t s);
        return s inside {SBL_BK_IDLE, SBL_BK_ACTIVE, SBL_BK_READ, SBL_BK_WRITE};
    endfunction : sbl_pre_ok
    // Decoded command and qualifiers; bank tables need normal state, gate high twice
    wire sbl_cmd_t cmd = sbl_decode(chip_select_n, row_strobe_n, column_strobe_n,
                                    write_strobe_n);
    wire is_nop = cmd == SBL_CMD_INHIBIT || cmd == SBL_CMD_NOP;
    wire ap = addr[SBL_AP_BIT];
    wire [1:0] sel = bank_select;
    wire gate_hh = gate_prev_r && clock_gate;
    wire gate_hl = gate_prev_r && !clock_gate;
    wire gate_lh = !gate_prev_r && clock_gate;
    wire gate_ll = !gate_prev_r && !clock_gate;
    wire table_on = dev_r == SBL_DV_NORMAL && gate_hh;
    wire frozen = dev_r == SBL_DV_SUSPEND;
    // Bank summaries for gate entry and precharge-all decisions
    always_comb begin
        any_burst = 1'b0;
        every_idle = 1'b1;
        every_pre_ok = 1'b1;
        for (int k = 0; k < SBL_BANKS; k++) begin
            any_burst = any_burst | (bank_r[k] inside {SBL_BK_READ, SBL_BK_WRITE,
                                                       SBL_BK_READ_AP, SBL_BK_WRITE_AP});
            every_idle = every_idle & (bank_r[k] == SBL_BK_IDLE);
            every_pre_ok = every_pre_ok & sbl_pre_ok(bank_r[k]);
        end
    end
    // Next state for banks and device
    always_comb begin
        logic bad;
        bad = 1'b0;
        dev_nxt = dev_r;
        dcnt_nxt = (dcnt_r != SBL_CNT_ZERO) ? dcnt_r - 8'h01 : dcnt_r;
        last_burst_nxt = last_burst_r;
        last_valid_nxt = last_valid_r;
        for (int k = 0; k < SBL_BANKS; k++) begin
            bank_nxt[k] = bank_r[k];
            // Timed exits continue under any legal command; suspend and refused commands freeze counters
            bcnt_nxt[k] = (bcnt_r[k] != SBL_CNT_ZERO && !frozen) ? bcnt_r[k] - 8'h01 : bcnt_r[k];
            if (bcnt_r[k] == 8'h01 && !frozen) begin
                case (bank_r[k])
                    SBL_BK_ACTIVATING: bank_nxt[k] = SBL_BK_ACTIVE;
                    SBL_BK_PRECHARGING: bank_nxt[k] = SBL_BK_IDLE;
                    SBL_BK_READ, SBL_BK_WRITE: bank_nxt[k] = SBL_BK_ACTIVE;
                    SBL_BK_READ_AP, SBL_BK_WRITE_AP: begin
                        bank_nxt[k] = SBL_BK_PRECHARGING;
                        bcnt_nxt[k] = SBL_PRECHARGE_CYC;
                    end
                    default: bank_nxt[k] = bank_r[k];
                endcase
            end
        end
        case (dev_r)
            SBL_DV_NORMAL: begin
                if (gate_hl) begin
                    if (any_burst) begin // Any command, nop too, suspends a burst
                        dev_nxt = SBL_DV_SUSPEND;
                    end else if (every_idle && is_nop) begin
                        dev_nxt = SBL_DV_POWER_DOWN;
                    end else if (every_idle && cmd == SBL_CMD_REFRESH) begin
                        dev_nxt = SBL_DV_SELF_REFRESH;
                    end else begin
                        bad = 1'b1;
                    end
                end else if (!gate_hh) begin
                    bad = 1'b1;
                end else if (table_on && !is_nop) begin
                    case (cmd)
                        SBL_CMD_REFRESH, SBL_CMD_MODE_LOAD: begin
                            if (every_idle) begin
                                dev_nxt = (cmd == SBL_CMD_REFRESH) ? SBL_DV_REFRESHING
                                                                    : SBL_DV_MODE_LOADING;
                                dcnt_nxt = (cmd == SBL_CMD_REFRESH) ? SBL_REFRESH_CYC
                                                                    : SBL_MODE_LOAD_CYC;
                            end else begin
                                bad = 1'b1;
                            end
                        end
                        SBL_CMD_ACTIVATE: begin
                            if (bank_r[sel] == SBL_BK_IDLE) begin
                                bank_nxt[sel] = SBL_BK_ACTIVATING;
                                bcnt_nxt[sel] = SBL_ACTIVATE_CYC;
                            end else begin
                                bad = 1'b1;
                            end
                        end
                        SBL_CMD_READ, SBL_CMD_WRITE: begin
                            if (bank_r[sel] inside {SBL_BK_ACTIVE, SBL_BK_READ,
                                                    SBL_BK_WRITE}) begin
                                bank_nxt[sel] = (cmd == SBL_CMD_READ)
                                    ? (ap ? SBL_BK_READ_AP : SBL_BK_READ)
                                    : (ap ? SBL_BK_WRITE_AP : SBL_BK_WRITE);
                                bcnt_nxt[sel] = SBL_BURST_CYC;
                                last_burst_nxt = sel;
                                last_valid_nxt = 1'b1;
                                // Interrupted burst in another bank ends
                                for (int k = 0; k < SBL_BANKS; k++) begin
                                    if (k != int'(sel) && bank_r[k] inside
                                        {SBL_BK_READ, SBL_BK_WRITE}) begin
                                        bank_nxt[k] = SBL_BK_ACTIVE;
                                        bcnt_nxt[k] = SBL_CNT_ZERO;
                                    end else if (k != int'(sel) && bank_r[k] inside
                                        {SBL_BK_READ_AP, SBL_BK_WRITE_AP}) begin
                                        bank_nxt[k] = SBL_BK_PRECHARGING;
                                        bcnt_nxt[k] = SBL_PRECHARGE_CYC;
                                    end
                                end
                            end else begin
                                bad = 1'b1;
                            end
                        end
                        SBL_CMD_TERMINATE: begin
                            if (last_valid_r && bank_r[last_burst_r] inside
                                {SBL_BK_READ, SBL_BK_WRITE}) begin
                                bank_nxt[last_burst_r] = SBL_BK_ACTIVE;
                                bcnt_nxt[last_burst_r] = SBL_CNT_ZERO;
                                last_valid_nxt = 1'b0;
                            end else begin
                                bad = 1'b1;
                            end
                        end
                        SBL_CMD_PRECHARGE: begin
                            if (ap) begin
                                if (every_pre_ok) begin
                                    dev_nxt = SBL_DV_PRECHARGE_ALL;
                                    dcnt_nxt = SBL_PRECHARGE_CYC;
                                    for (int k = 0; k < SBL_BANKS; k++) begin
                                        bank_nxt[k] = SBL_BK_IDLE;
                                        bcnt_nxt[k] = SBL_CNT_ZERO;
                                    end
                                end else begin
                                    bad = 1'b1;
                                end
                            end else if (bank_r[sel] == SBL_BK_IDLE) begin
                                bank_nxt[sel] = SBL_BK_IDLE;
                            end else if (sbl_pre_ok(bank_r[sel])) begin
                                bank_nxt[sel] = SBL_BK_PRECHARGING;
                                bcnt_nxt[sel] = SBL_PRECHARGE_CYC;
                            end else begin
                                bad = 1'b1;
                            end
                        end
                        default: bad = 1'b1;
                    endcase
                end
            end
            SBL_DV_POWER_DOWN, SBL_DV_SELF_REFRESH, SBL_DV_SUSPEND: begin
                if (gate_lh) begin
                    if (dev_r == SBL_DV_SUSPEND) begin
                        dev_nxt = SBL_DV_NORMAL;
                    end else if (!is_nop) begin
                        bad = 1'b1;
                    end else if (dev_r == SBL_DV_POWER_DOWN) begin
                        dev_nxt = SBL_DV_NORMAL;
                    end else begin
                        dev_nxt = SBL_DV_SR_EXIT;
                        dcnt_nxt = SBL_SR_EXIT_CYC;
                    end
                end else if (!gate_ll) begin
                    bad = 1'b1;
                end
            end
            SBL_DV_SR_EXIT, SBL_DV_REFRESHING, SBL_DV_MODE_LOADING,
            SBL_DV_PRECHARGE_ALL: begin
                // Only nops with the gate high while waiting
                if (!is_nop || !clock_gate) begin
                    bad = 1'b1;
                end
                if (dcnt_r <= 8'h01) begin
                    dev_nxt = SBL_DV_NORMAL;
                end
            end
            default: dev_nxt = SBL_DV_NORMAL;
        endcase
        // Illegal sequences leave bank and device state untouched; the device wait counter still counts
        if (bad) begin
            dev_nxt = dev_r;
            last_burst_nxt = last_burst_r;
            last_valid_nxt = last_valid_r;
            for (int k = 0; k < SBL_BANKS; k++) begin
                bank_nxt[k] = bank_r[k];
                bcnt_nxt[k] = bcnt_r[k];
            end
        end
        illegal_nxt = bad;
        for (int k = 0; k < SBL_BANKS; k++) begin
            bank_state_nxt[k*4 +: 4] = {1'b0, bank_nxt[k]};
        end
    end
    // State registers and observed outputs; every output comes from a flop
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int k = 0; k < SBL_BANKS; k++) begin
                bank_r[k] <= SBL_BK_IDLE;
                bcnt_r[k] <= SBL_CNT_ZERO;
            end
            dev_r <= SBL_DV_NORMAL;
            dcnt_r <= SBL_CNT_ZERO;
            gate_prev_r <= 1'b1;
            last_burst_r <= 2'h0;
            last_valid_r <= 1'b0;
            bank_state <= 16'h0000;
            dev_state <= 3'h0;
            all_idle <= 1'b1;
            illegal <= 1'b0;
        end else begin
            for (int k = 0; k < SBL_BANKS; k++) begin
                bank_r[k] <= bank_nxt[k];
                bcnt_r[k] <= bcnt_nxt[k];
            end
            dev_r <= dev_nxt;
            dcnt_r <= dcnt_nxt;
            gate_prev_r <= clock_gate;
            last_burst_r <= last_burst_nxt;
            last_valid_r <= last_valid_nxt;
            bank_state <= bank_state_nxt;
            dev_state <= dev_nxt;
            all_idle <= bank_state_nxt == 16'h0000;
            illegal <= illegal_nxt;
        end
    end
endmodule : sbl_bank_state_legality
`default_nettype wire
